// >>> srrs_exec.sv
`default_nettype none
// Overview of operation
// RL1: return 0x0008 loads counter from popped stack top, flags untouched, two cycles.
// RL2: rotate right: carry into bit 7, bit 0 into carry, one cycle.
// RL3: rotate destination bit 0 writes accumulator, 1 writes file register 0..127.
// RL4: literal-subtract computes literal minus accumulator, two's complement, one cycle.
// RL5: literal-subtract writes accumulator, updates carry, digit-carry, zero; no file write.
// RL6: carry set to 1 when difference is positive (inverted borrow).
// RL7: carry cleared when accumulator exceeds literal, set when result zero.
// RL8: zero flag when result is zero; digit-carry when no low-nibble borrow.
module srrs_exec (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic instrValid,
    input wire logic [13:0] instrWord,
    input wire logic [7:0] accIn,
    input wire logic [7:0] fileRdData,
    input wire logic carryIn,
    input wire logic [12:0] stackTopEntry,
    output logic busy,
    output logic [6:0] fileAddr,
    output logic stackPop,
    output logic pcLoad,
    output logic [12:0] programCounter,
    output logic accWrite,
    output logic [7:0] accData,
    output logic fileWrite,
    output logic [7:0] fileWrData,
    output logic flagWrite,
    output logic carryFlag,
    output logic digitCarryFlag,
    output logic zeroFlag
);
    typedef enum logic [0:0] {SRRS_IDLE = 1'b0, SRRS_RETWAIT = 1'b1} srrs_state_type;
    typedef struct packed {
        srrs_state_type st;
        logic busy;
        logic stackPop;
        logic pcLoad;
        logic [12:0] progCnt;
        logic [6:0] fileAddr;
        logic accWrite;
        logic [7:0] accData;
        logic fileWrite;
        logic [7:0] fileWrData;
        logic flagWrite;
        logic carry;
        logic dcarry;
        logic zero;
    } srrs_regs_type;
    srrs_regs_type state_ff, nxt_state;
    logic [8:0] diff;
    logic [4:0] lowDiff;
    logic [7:0] rotated;
    logic isRet, isRot, isSub;
    always_comb
    begin
        isRet = instrValid && instrWord == srrs_pkg::RETURN_CODE;
        isRot = instrValid && instrWord[13:8] == srrs_pkg::ROT_PREFIX;
        isSub = instrValid && instrWord[13:9] == srrs_pkg::SUBL_PREFIX;
        // RL4 literal minus accumulator
        diff = {1'b0, instrWord[7:0]} - {1'b0, accIn};
        lowDiff = {1'b0, instrWord[3:0]} - {1'b0, accIn[3:0]};
        // RL2 rotate through carry
        rotated = {carryIn, fileRdData[7:1]};
        nxt_state = state_ff;
        nxt_state.stackPop = 1'b0;
        nxt_state.pcLoad = 1'b0;
        nxt_state.accWrite = 1'b0;
        nxt_state.fileWrite = 1'b0;
        nxt_state.flagWrite = 1'b0;
        case (state_ff.st)
            SRRS_IDLE:
            begin
                nxt_state.busy = 1'b0;
                if (isRet)
                begin
                    // RL1 pop and load counter, no flags
                    nxt_state.stackPop = 1'b1;
                    nxt_state.pcLoad = 1'b1;
                    nxt_state.progCnt = stackTopEntry;
                    nxt_state.busy = 1'b1;
                    nxt_state.st = SRRS_RETWAIT;
                end
                else if (isRot)
                begin
                    // RL3 destination select
                    nxt_state.accWrite = !instrWord[srrs_pkg::DEST_BIT];
                    nxt_state.fileWrite = instrWord[srrs_pkg::DEST_BIT];
                    nxt_state.accData = rotated;
                    nxt_state.fileWrData = rotated;
                    nxt_state.flagWrite = 1'b1;
                    nxt_state.carry = fileRdData[0];
                    // address goes out with the write as the file target; fetch already presented the read data
                    nxt_state.fileAddr = instrWord[6:0];
                end
                else if (isSub)
                begin
                    // RL5 accumulator only
                    nxt_state.accWrite = 1'b1;
                    nxt_state.accData = diff[7:0];
                    nxt_state.flagWrite = 1'b1;
                    // RL6 RL7 carry is inverted borrow
                    nxt_state.carry = !diff[8];
                    // RL8 zero and digit-carry
                    nxt_state.zero = diff[7:0] == 8'h00;
                    nxt_state.dcarry = !lowDiff[4];
                end
            end
            SRRS_RETWAIT:
            begin
                // second cycle of return is a bubble
                nxt_state.busy = 1'b0;
                nxt_state.st = SRRS_IDLE;
            end
            default:
            begin
                nxt_state.st = SRRS_IDLE;
                nxt_state.busy = 1'b0;
            end
        endcase
        if (srst)
        begin
            nxt_state = '0;
            nxt_state.progCnt = srrs_pkg::PROG_CNT_RESET;
        end
    end
    always_ff @(posedge sys_clk)
    begin
        state_ff <= nxt_state;
    end
    assign busy = state_ff.busy;
    assign fileAddr = state_ff.fileAddr;
    assign stackPop = state_ff.stackPop;
    assign pcLoad = state_ff.pcLoad;
    assign programCounter = state_ff.progCnt;
    assign accWrite = state_ff.accWrite;
    assign accData = state_ff.accData;
    assign fileWrite = state_ff.fileWrite;
    assign fileWrData = state_ff.fileWrData;
    assign flagWrite = state_ff.flagWrite;
    assign carryFlag = state_ff.carry;
    assign digitCarryFlag = state_ff.dcarry;
    assign zeroFlag = state_ff.zero;

    // RL1 two-cycle return
    a_ret_two_cycle: assert property (@(posedge sys_clk) disable iff (srst) // RL1
        (isRet && state_ff.st == SRRS_IDLE) |=> busy && pcLoad && programCounter == $past(stackTopEntry) ##1 !busy)
        else $error("return not two cycles");

    // RL1 no writes on return
    a_ret_no_flags: assert property (@(posedge sys_clk) disable iff (srst) // RL1
        pcLoad |-> !flagWrite && !accWrite && !fileWrite)
        else $error("return touched flags");

    // RL1 flags hold on return
    a_ret_flags_hold: assert property (@(posedge sys_clk) disable iff (srst) // RL1
        pcLoad |-> $stable(carryFlag) && $stable(digitCarryFlag) && $stable(zeroFlag) && $stable(accData))
        else $error("return changed flags or accumulator");

    // RL1 single stack pop
    a_ret_pop_once: assert property (@(posedge sys_clk) disable iff (srst) // RL1
        stackPop |=> !stackPop && !pcLoad)
        else $error("stack popped twice");

    // RL1 second cycle ignored
    a_ret_bubble: assert property (@(posedge sys_clk) disable iff (srst) // RL1
        (state_ff.st == SRRS_RETWAIT) |=> !accWrite && !fileWrite && !flagWrite && !pcLoad)
        else $error("instruction taken in return bubble");

    // RL2 rotate through carry
    a_rotate_value: assert property (@(posedge sys_clk) disable iff (srst) // RL2
        (isRot && state_ff.st == SRRS_IDLE) |=> accData == {$past(carryIn), $past(fileRdData[7:1])}
        && carryFlag == $past(fileRdData[0]))
        else $error("rotate wrong");

    // RL2 single cycle rotate
    a_rotate_one_cycle: assert property (@(posedge sys_clk) disable iff (srst) // RL2
        (isRot && state_ff.st == SRRS_IDLE) |=> flagWrite && !busy && !pcLoad)
        else $error("rotate not single cycle");

    // RL2 only carry changes
    a_rotate_keeps: assert property (@(posedge sys_clk) disable iff (srst) // RL2
        (isRot && state_ff.st == SRRS_IDLE) |=> digitCarryFlag == $past(digitCarryFlag)
        && zeroFlag == $past(zeroFlag))
        else $error("rotate changed other flags");

    // RL3 destination select
    a_rotate_dest: assert property (@(posedge sys_clk) disable iff (srst) // RL3
        (isRot && state_ff.st == SRRS_IDLE) |=> fileWrite == $past(instrWord[7]) && accWrite != fileWrite)
        else $error("rotate destination wrong");

    // RL3 file data and address
    a_rotate_data: assert property (@(posedge sys_clk) disable iff (srst) // RL3
        (isRot && state_ff.st == SRRS_IDLE) |=> fileWrData == accData && fileAddr == $past(instrWord[6:0]))
        else $error("rotate file data or address wrong");

    // RL4 literal minus accumulator
    a_sub_value: assert property (@(posedge sys_clk) disable iff (srst) // RL4
        (isSub && state_ff.st == SRRS_IDLE) |=> accWrite && accData == 8'($past(instrWord[7:0]) - $past(accIn)))
        else $error("subtract value wrong");

    // RL5 accumulator only
    a_sub_no_file: assert property (@(posedge sys_clk) disable iff (srst) // RL5
        (isSub && state_ff.st == SRRS_IDLE) |=> !fileWrite && flagWrite)
        else $error("subtract wrote file");

    // RL6 carry when positive
    a_sub_carry_pos: assert property (@(posedge sys_clk) disable iff (srst) // RL6
        (isSub && state_ff.st == SRRS_IDLE && instrWord[7:0] >= accIn) |=> carryFlag)
        else $error("carry not set");

    // RL7 borrow clears carry
    a_sub_carry_neg: assert property (@(posedge sys_clk) disable iff (srst) // RL7
        (isSub && state_ff.st == SRRS_IDLE && accIn > instrWord[7:0]) |=> !carryFlag)
        else $error("carry not cleared");

    // RL8 zero and digit-carry
    a_sub_zero_digit: assert property (@(posedge sys_clk) disable iff (srst) // RL8
        (isSub && state_ff.st == SRRS_IDLE) |=> zeroFlag == ($past(instrWord[7:0]) == $past(accIn))
        && digitCarryFlag == ($past(instrWord[3:0]) >= $past(accIn[3:0])))
        else $error("zero or digit carry wrong");
endmodule
`default_nettype wire

// >>> srrs_exec_tb.sv
`default_nettype none
module srrs_exec_tb;
timeunit 1ns;
timeprecision 1ps;
logic sys_clk = 0, srst = 1, instrValid = 0, carryIn = 0;
logic [13:0] instrWord = '0;
logic [7:0] accIn = '0, fileRdData = '0, accData, fileWrData;
logic [12:0] stackTopEntry = '0, programCounter, mProgCnt = '0;
logic busy, stackPop, pcLoad, accWrite, fileWrite, flagWrite, carryFlag, digitCarryFlag, zeroFlag;
logic [6:0] fileAddr, mFa = '0;
logic mC = 0, mDigit = 0, mZ = 0;
logic [36:0] notes[$], seen;
logic [31:0] rnd = 32'h2f84;
int n_errors = 0, checks = 0;
always #10 sys_clk = ~sys_clk;
srrs_exec dut (.sys_clk(sys_clk), .srst(srst), .instrValid(instrValid), .instrWord(instrWord), .accIn(accIn),
    .fileRdData(fileRdData), .carryIn(carryIn), .stackTopEntry(stackTopEntry), .busy(busy), .fileAddr(fileAddr),
    .stackPop(stackPop), .pcLoad(pcLoad), .programCounter(programCounter), .accWrite(accWrite), .accData(accData),
    .fileWrite(fileWrite), .fileWrData(fileWrData), .flagWrite(flagWrite), .carryFlag(carryFlag),
    .digitCarryFlag(digitCarryFlag), .zeroFlag(zeroFlag));
function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
endfunction
task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
endtask
// keep low: instruction must be ignored, so no note and no model update
task automatic exec(input logic [13:0] w, input logic [7:0] a, input logic [7:0] f, input logic ci, input logic keep);
    logic [8:0] d;
    @(negedge sys_clk);
    rnd = lfsr(rnd);
    {instrWord, accIn, fileRdData, carryIn, stackTopEntry} = {w, a, f, ci, rnd[12:0]};
    instrValid = 1'b1;
    d = {1'b0, w[7:0]} - {1'b0, a};
    if (keep && w == srrs_pkg::RETURN_CODE)
        mProgCnt = rnd[12:0];
    if (keep && w == srrs_pkg::RETURN_CODE)
        notes.push_back({6'h26, 8'h00, mProgCnt, mFa, mC, mDigit, mZ});
    if (keep && w[13:8] == srrs_pkg::ROT_PREFIX)
        {mC, mFa} = {f[0], w[6:0]};
    if (keep && w[13:8] == srrs_pkg::ROT_PREFIX)
        notes.push_back({1'b0, !w[7], w[7], 3'h1, ci, f[7:1], mProgCnt, mFa, mC, mDigit, mZ});
    if (keep && w[13:9] == srrs_pkg::SUBL_PREFIX)
        {mC, mDigit, mZ} = {!d[8], w[3:0] >= a[3:0], d[7:0] == 8'h00};
    if (keep && w[13:9] == srrs_pkg::SUBL_PREFIX)
        notes.push_back({6'h11, d[7:0], mProgCnt, mFa, mC, mDigit, mZ});
endtask
always @(posedge sys_clk)
begin
    #1;
    if (srst === 1'b0 && (accWrite | fileWrite | pcLoad) === 1'b1)
    begin
        seen = {busy, accWrite, fileWrite, pcLoad, stackPop, flagWrite, accWrite ? accData : fileWrite ? fileWrData
            : 8'h00, programCounter, fileAddr, carryFlag, digitCarryFlag, zeroFlag};
        checks++;
        if (notes.size() == 0 || seen !== notes[0])
        begin
            n_errors++;
            $display("unexpected result: expected %h seen %h", notes.size() ? notes[0] : 37'h0, seen);
        end
        if (notes.size() != 0)
            void'(notes.pop_front());
    end
end
initial
begin
    logic [15:0] ka;
    static logic [15:0] tbl [5] = '{16'h0201, 16'h0202, 16'h0203, 16'h1001, 16'hff00};
    static logic [13:0] odd [4] = '{14'h0009, 14'h0d85, 14'h0285, 14'h3405};
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    srst = 1'b0;
    for (int i = 0; i < 24; i++)
        exec({srrs_pkg::ROT_PREFIX, rnd[8], (i == 0 ? 7'h7f : rnd[6:0])}, rnd[15:8], rnd[23:16], rnd[24], 1'b1);
    $display("rotate test done");
    for (int i = 0; i < 24; i++)
    begin
        ka = i < 5 ? tbl[i] : rnd[15:0];
        exec({srrs_pkg::SUBL_PREFIX, rnd[16], ka[15:8]}, ka[7:0], rnd[31:24], rnd[17], 1'b1);
    end
    $display("subtract test done");
    // second return cycle swallows whatever is offered, even another return
    for (int i = 0; i < 4; i++)
    begin
        exec(srrs_pkg::RETURN_CODE, rnd[7:0], rnd[15:8], rnd[16], 1'b1);
        exec(i[0] ? srrs_pkg::RETURN_CODE : 14'h0c85, rnd[7:0], rnd[15:8], rnd[16], 1'b0);
    end
    $display("return test done");
    foreach (odd[i])
        exec(odd[i], rnd[7:0], rnd[15:8], rnd[16], 1'b0);
    exec(14'h0c01, 8'h00, 8'h02, 1'b1, 1'b1);
    $display("unknown encoding test done");
    @(negedge sys_clk);
    instrValid = 1'b0;
    repeat (3) @(posedge sys_clk);
    #2;
    if (notes.size() != 0)
    begin
        n_errors++;
        $display("unexpected pending notes: expected 0 seen %0d", notes.size());
    end
    report_and_stop();
end
endmodule
`default_nettype wire

// >>> srrs_pkg.sv
`default_nettype none
package srrs_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int PROG_CNT_W = 13;
    localparam logic [13:0] RETURN_CODE = 14'h0008;
    localparam logic [5:0] ROT_PREFIX = 6'h0c;
    localparam logic [4:0] SUBL_PREFIX = 5'h1e;
    localparam int DEST_BIT = 7;
    localparam int RETURN_CYCLES = 2;
    localparam logic [PROG_CNT_W-1:0] PROG_CNT_RESET = 13'h0000;
endpackage
`default_nettype wire
